// >>> core/sadc_pkg.sv
// Shared constants and types of the serial converter control block.
package sadc_pkg;
  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int unsigned CLK_PERIOD_NS = 20;
  localparam int unsigned CONV_TIME_NS = 5000;
  localparam int unsigned WAKE_TIME_NS = 5000;
  localparam int unsigned DATA_HOLD_NS = 10;
  localparam int unsigned CONV_CYC = CONV_TIME_NS / CLK_PERIOD_NS;
  localparam int unsigned WAKE_CYC = WAKE_TIME_NS / CLK_PERIOD_NS;
  localparam int unsigned HOLD_RAW = (DATA_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned HOLD_CYC = (HOLD_RAW < 1) ? 1 : HOLD_RAW;
  localparam int unsigned READ_GUARD_NS = 250;
  localparam int unsigned READ_GUARD_CYC = (READ_GUARD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // ----------------------------------------------------------------
  // Widths
  // ----------------------------------------------------------------
  localparam int unsigned RESULT_BITS = 14;
  localparam int unsigned FRAME_BITS = 16;
  localparam int unsigned CNT_W = 9;
  localparam int unsigned HOLD_W = 2;
  localparam int unsigned BITS_W = 5;
  localparam int unsigned BUF_DEPTH = 2;
  // ----------------------------------------------------------------
  // Control states
  // ----------------------------------------------------------------
  typedef enum logic [3:0] {
    ST_ACTIVE = 4'h1,
    ST_CONVERT = 4'h2,
    ST_SLEEP = 4'h4,
    ST_WAKE = 4'h8
  } sadc_state_type;
endpackage : sadc_pkg

// >>> core/sadc_buf_if.sv
// Handshake bundle between the conversion logic and the result buffer.
interface sadc_buf_if #(parameter int unsigned WIDTH = 14);
  logic push_valid;
  logic push_ready;
  logic [WIDTH-1:0] push_data;
  logic pop_valid;
  logic pop_ready;
  logic [WIDTH-1:0] pop_data;
  modport store (input push_valid, input push_data, input pop_ready,
                 output push_ready, output pop_valid, output pop_data);
  modport user (output push_valid, output push_data, output pop_ready,
                input push_ready, input pop_valid, input pop_data);
endinterface : sadc_buf_if

// >>> core/sadc_fifo.sv
// Small result buffer with valid and ready on both sides.
module sadc_fifo #(
  parameter int unsigned WIDTH = 14,
  parameter int unsigned DEPTH = 2
) (
  input logic clk,
  input logic rst_n,
  sadc_buf_if.store bi
);
  localparam int unsigned PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int unsigned CW = $clog2(DEPTH + 1);

  logic [WIDTH-1:0] mem_r [DEPTH];
  logic [WIDTH-1:0] mem_nxt [DEPTH];
  logic [PW-1:0] wr_r, wr_nxt, rd_r, rd_nxt;
  logic [CW-1:0] count_r, count_nxt;
  logic do_push, do_pop;

  assign bi.push_ready = (count_r != CW'(DEPTH));
  assign bi.pop_valid = (count_r != '0);
  assign bi.pop_data = mem_r[rd_r];
  assign do_push = bi.push_valid & bi.push_ready;
  assign do_pop = bi.pop_valid & bi.pop_ready;

  always_comb begin
    mem_nxt = mem_r;
    wr_nxt = wr_r;
    rd_nxt = rd_r;
    count_nxt = count_r;
    if (do_push) begin
      mem_nxt[wr_r] = bi.push_data;
      wr_nxt = (wr_r == PW'(DEPTH - 1)) ? '0 : PW'(wr_r + 1'b1);
    end
    if (do_pop) begin
      rd_nxt = (rd_r == PW'(DEPTH - 1)) ? '0 : PW'(rd_r + 1'b1);
    end
    if (do_push && !do_pop) begin
      count_nxt = CW'(count_r + 1'b1);
    end else if (do_pop && !do_push) begin
      count_nxt = CW'(count_r - 1'b1);
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      wr_r <= '0;
      rd_r <= '0;
      count_r <= '0;
      for (int i = 0; i < DEPTH; i++) begin
        mem_r[i] <= '0;
      end
    end else begin
      wr_r <= wr_nxt;
      rd_r <= rd_nxt;
      count_r <= count_nxt;
      mem_r <= mem_nxt;
    end
  end
endmodule : sadc_fifo

// >>> core/sadc_top.sv
// Conversion control and serial readout of the 14-bit converter.
// Operation
// R1: New output bit driven on serial clock fall.
// R2: Previous bit stays valid briefly after fall.
// R3: Host parks serial clock low after frame.
// R4: Frame is two zeros then fourteen bits.
// R5: Sixteenth fall holds bit, then releases output.
// R6: Bipolar two's complement, unipolar straight binary.
// R7: Busy rises on convert start falling edge.
// R8: Busy falls once conversion completes.
// R9: Start fall freezes sample, begins conversion.
// R10: Start still low at end enters power-down.
// R11: Start rising edge in power-down begins wake-up.
// R12: Internal conversion timing; sleep mode takes longer.
// R13: Host avoids reading during or before conversion.
// R14: Most significant bit first, sixteen falls.
module sadc_top #(
  parameter bit BIPOLAR = 1'b1,
  parameter int unsigned DEPTH = sadc_pkg::BUF_DEPTH
) (
  input logic clk,
  input logic rst_n,
  input logic convert_start_n,
  input logic serial_clk,
  input logic [13:0] sample_code,
  output logic serial_out,
  output logic serial_out_en,
  output logic busy,
  output logic hold_mode,
  output logic power_down
);
  localparam int unsigned CW = sadc_pkg::CNT_W;
  localparam int unsigned HW = sadc_pkg::HOLD_W;
  localparam int unsigned BW = sadc_pkg::BITS_W;
  localparam int unsigned RB = sadc_pkg::RESULT_BITS;
  localparam int unsigned FB = sadc_pkg::FRAME_BITS;

  // ----------------------------------------------------------------
  // Pin synchronisers and edge detection
  // ----------------------------------------------------------------
  logic cs_meta_r, cs_sync_r, cs_prev_r;
  logic sc_meta_r, sc_sync_r, sc_prev_r;
  logic cs_fall, cs_rise, sc_fall;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      cs_meta_r <= 1'b1;
      cs_sync_r <= 1'b1;
      cs_prev_r <= 1'b1;
      sc_meta_r <= 1'b0;
      sc_sync_r <= 1'b0;
      sc_prev_r <= 1'b0;
    end else begin
      cs_meta_r <= convert_start_n;
      cs_sync_r <= cs_meta_r;
      cs_prev_r <= cs_sync_r;
      sc_meta_r <= serial_clk;
      sc_sync_r <= sc_meta_r;
      sc_prev_r <= sc_sync_r;
    end
  end

  assign cs_fall = cs_prev_r & ~cs_sync_r;
  assign cs_rise = ~cs_prev_r & cs_sync_r;
  // Only falling edges are counted, so the clock must rest low between frames. [R3]
  assign sc_fall = sc_prev_r & ~sc_sync_r;

  sadc_buf_if #(.WIDTH(RB)) bi ();

  sadc_fifo #(.WIDTH(RB), .DEPTH(DEPTH)) u_buf (
    .clk(clk),
    .rst_n(rst_n),
    .bi(bi)
  );

  // ----------------------------------------------------------------
  // Conversion control
  // ----------------------------------------------------------------
  sadc_pkg::sadc_state_type state_r, state_nxt;
  logic [CW-1:0] cnt_r, cnt_nxt;
  logic pend_r, pend_nxt;
  logic [RB-1:0] held_r, held_nxt;

  always_comb begin
    state_nxt = state_r;
    cnt_nxt = cnt_r;
    pend_nxt = pend_r;
    held_nxt = held_r;
    bi.push_valid = 1'b0;
    unique case (state_r)
      sadc_pkg::ST_ACTIVE: begin
        if (cs_fall) begin
          state_nxt = sadc_pkg::ST_CONVERT; // [R9]
          cnt_nxt = CW'(sadc_pkg::CONV_CYC - 1); // [R12]
          held_nxt = sample_code; // [R9]
        end
      end
      sadc_pkg::ST_CONVERT: begin
        if (cnt_r != '0) begin
          cnt_nxt = CW'(cnt_r - 1'b1);
        end else begin
          // A full buffer stalls the end of conversion so no result is lost.
          bi.push_valid = 1'b1;
          if (bi.push_ready) begin
            state_nxt = cs_sync_r ? sadc_pkg::ST_ACTIVE : sadc_pkg::ST_SLEEP; // [R8] [R10]
          end
        end
      end
      sadc_pkg::ST_SLEEP: begin
        if (cs_rise) begin
          state_nxt = sadc_pkg::ST_WAKE; // [R11]
          cnt_nxt = CW'(sadc_pkg::WAKE_CYC - 1); // [R12]
          pend_nxt = 1'b0;
        end
      end
      sadc_pkg::ST_WAKE: begin
        if (cs_fall) begin
          pend_nxt = 1'b1;
          held_nxt = sample_code; // [R9]
        end
        if (cnt_r != '0) begin
          cnt_nxt = CW'(cnt_r - 1'b1);
        end else if (pend_r || cs_fall) begin
          // Conversion follows wake-up, which is why sleep mode is slower.
          state_nxt = sadc_pkg::ST_CONVERT; // [R12]
          cnt_nxt = CW'(sadc_pkg::CONV_CYC - 1);
          pend_nxt = 1'b0;
        end else begin
          state_nxt = sadc_pkg::ST_ACTIVE;
        end
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      state_r <= sadc_pkg::ST_ACTIVE;
      cnt_r <= '0;
      pend_r <= 1'b0;
      held_r <= '0;
    end else begin
      state_r <= state_nxt;
      cnt_r <= cnt_nxt;
      pend_r <= pend_nxt;
      held_r <= held_nxt;
    end
  end

  // The ladder code is offset binary; bipolar parts flip the top bit.
  assign bi.push_data = {held_r[RB-1] ^ BIPOLAR, held_r[RB-2:0]}; // [R6]
  assign busy = (state_r == sadc_pkg::ST_CONVERT) ||
                ((state_r == sadc_pkg::ST_WAKE) && pend_r); // [R7] [R8]
  assign hold_mode = busy; // [R9]
  assign power_down = (state_r == sadc_pkg::ST_SLEEP); // [R10]

  // ----------------------------------------------------------------
  // Serial readout
  // ----------------------------------------------------------------
  logic [FB-1:0] sh_r, sh_nxt;
  logic [BW-1:0] bits_r, bits_nxt;
  logic [HW-1:0] hold_r, hold_nxt;
  logic en_r, en_nxt;

  always_comb begin
    sh_nxt = sh_r;
    bits_nxt = bits_r;
    hold_nxt = hold_r;
    en_nxt = en_r;
    bi.pop_ready = ~en_r;
    if (!en_r) begin
      if (bi.pop_valid) begin
        sh_nxt = {2'b00, bi.pop_data}; // [R4]
        bits_nxt = '0;
        en_nxt = 1'b1;
      end
    end else if (hold_r != '0) begin
      hold_nxt = HW'(hold_r - 1'b1);
      if (hold_r == HW'(1)) begin
        en_nxt = 1'b0; // [R5]
      end
    end else if (sc_fall) begin
      if (bits_r == BW'(FB - 1)) begin
        hold_nxt = HW'(sadc_pkg::HOLD_CYC); // [R5]
      end else begin
        sh_nxt = {sh_r[FB-2:0], 1'b0}; // [R1] [R14]
      end
      bits_nxt = BW'(bits_r + 1'b1);
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      sh_r <= '0;
      bits_r <= '0;
      hold_r <= '0;
      en_r <= 1'b0;
    end else begin
      sh_r <= sh_nxt;
      bits_r <= bits_nxt;
      hold_r <= hold_nxt;
      en_r <= en_nxt;
    end
  end

  // The bit changes only after the detected edge, so it outlasts the host's edge. [R2]
  assign serial_out = sh_r[FB-1];
  assign serial_out_en = en_r;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  chk_busy_rise: assert property (@(posedge clk) disable iff (!rst_n) // [R7]
    (state_r == sadc_pkg::ST_ACTIVE && cs_fall) |=> busy)
    else $error("busy did not rise on start fall");
  chk_wake_busy: assert property (@(posedge clk) disable iff (!rst_n) // [R7]
    (state_r == sadc_pkg::ST_WAKE && cs_fall) |=> busy)
    else $error("busy did not rise on start fall in wake-up");
  chk_busy_fall: assert property (@(posedge clk) disable iff (!rst_n) // [R8]
    (state_r == sadc_pkg::ST_CONVERT && cnt_r == '0 && bi.push_ready) |=> !busy)
    else $error("busy stayed high after conversion");
  chk_conv_time: assert property (@(posedge clk) disable iff (!rst_n) // [R12]
    (state_r == sadc_pkg::ST_ACTIVE && cs_fall) |=>
      (cnt_r == CW'(sadc_pkg::CONV_CYC - 1)) ##1 (busy && cnt_r == CW'(sadc_pkg::CONV_CYC - 2)))
    else $error("conversion count wrong");
  chk_hold_entry: assert property (@(posedge clk) disable iff (!rst_n) // [R9]
    (state_r == sadc_pkg::ST_ACTIVE && cs_fall) |=> hold_mode && held_r == $past(sample_code))
    else $error("sample not frozen on start fall");
  chk_sleep_entry: assert property (@(posedge clk) disable iff (!rst_n) // [R10]
    (state_r == sadc_pkg::ST_CONVERT && cnt_r == '0 && bi.push_ready && !cs_sync_r)
      |=> power_down)
    else $error("no power-down with start low");
  chk_wake_start: assert property (@(posedge clk) disable iff (!rst_n) // [R11]
    (power_down && cs_rise) |=> !power_down && state_r == sadc_pkg::ST_WAKE)
    else $error("wake-up did not start");
  chk_lead_zero: assert property (@(posedge clk) disable iff (!rst_n) // [R4]
    (!en_r && bi.pop_valid) |=>
      serial_out_en && sh_r[FB-1:FB-2] == 2'b00 && sh_r[RB-1:0] == $past(bi.pop_data))
    else $error("frame not two zeros and result");
  chk_shift_msb: assert property (@(posedge clk) disable iff (!rst_n) // [R1]
    (en_r && hold_r == '0 && sc_fall && bits_r < BW'(FB - 1)) |=>
      serial_out == $past(sh_r[FB-2]))
    else $error("next bit not driven on fall");
  chk_bit_hold: assert property (@(posedge clk) disable iff (!rst_n) // [R2]
    (en_r && sc_fall) |-> $stable(serial_out))
    else $error("bit changed in the edge cycle");
  chk_release: assert property (@(posedge clk) disable iff (!rst_n) // [R5]
    (en_r && hold_r == '0 && sc_fall && bits_r == BW'(FB - 1)) |=>
      (serial_out_en && $stable(serial_out)) ##1 !serial_out_en)
    else $error("output not released after last bit");
  chk_coding: assert property (@(posedge clk) disable iff (!rst_n) // [R6]
    (bi.push_valid && bi.push_ready) |=>
      $past(bi.push_data[RB-1]) == ($past(held_r[RB-1]) ^ BIPOLAR))
    else $error("result coding wrong");
endmodule : sadc_top

// >>> testbench/sadc_host_model.sv
// Host model that clocks one readout frame out of the converter.
module sadc_host_model (
  input wire logic clk,
  input wire logic serial_out,
  input wire logic serial_out_uni,
  output logic serial_clk
);
  timeunit 1ns;
  timeprecision 1ns;
  // ----------------------------------------------------------------
  // Serial clock generation and capture
  // ----------------------------------------------------------------
  // The serial clock rests low and only runs inside a frame.
  initial begin
    serial_clk = 1'b0;
  end
  // Each bit is taken just before the falling edge that replaces it, which is
  // half a clock before the host drives serial_clk low.
  task automatic read_frame(output logic [15:0] w, output logic [15:0] wu);
    for (int i = 15; i >= 0; i--) begin
      @(posedge clk);
      serial_clk <= 1'b1;
      repeat (3) @(posedge clk);
      @(negedge clk);
      w[i] = serial_out;
      wu[i] = serial_out_uni;
      @(posedge clk);
      serial_clk <= 1'b0;
      repeat (3) @(posedge clk);
    end
  endtask : read_frame
endmodule : sadc_host_model

// >>> testbench/sadc_top_tb_top.sv
// Self-checking testbench of the converter control and readout block.
`define SADC_CHK(a, b) cmp(16'(a), 16'(b))
module sadc_top_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk;
  logic rst_n;
  logic convert_start_n;
  logic serial_clk;
  logic [13:0] sample_code;
  logic serial_out;
  logic serial_out_en;
  logic busy;
  logic hold_mode;
  logic power_down;
  logic serial_out_uni;
  int fail_count = 0;
  int checks = 0;
  // ----------------------------------------------------------------
  // Design, host and clock
  // ----------------------------------------------------------------
  sadc_top #(.BIPOLAR(1'b1), .DEPTH(sadc_pkg::BUF_DEPTH)) dut (
    .clk(clk), .rst_n(rst_n), .convert_start_n(convert_start_n),
    .serial_clk(serial_clk), .sample_code(sample_code), .serial_out(serial_out),
    .serial_out_en(serial_out_en), .busy(busy), .hold_mode(hold_mode),
    .power_down(power_down));
  // A straight-binary copy runs in lockstep so both codings are read in one frame.
  sadc_top #(.BIPOLAR(1'b0), .DEPTH(sadc_pkg::BUF_DEPTH)) dut_uni (
    .clk(clk), .rst_n(rst_n), .convert_start_n(convert_start_n),
    .serial_clk(serial_clk), .sample_code(sample_code), .serial_out(serial_out_uni),
    .serial_out_en(), .busy(), .hold_mode(), .power_down());
  sadc_host_model host (.clk(clk), .serial_out(serial_out), .serial_out_uni(serial_out_uni),
    .serial_clk(serial_clk));
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  task automatic end_of_test();
    $display("checks=%0d fail_count=%0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : end_of_test
  task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
    checks++;
    if (got !== exp) begin
      fail_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : cmp
  function automatic logic sig(input int s);
    return (s == 0) ? busy : (s == 1) ? serial_out_en : power_down;
  endfunction : sig
  // Bipolar coding flips the top bit of the offset-binary core code.
  function automatic logic [15:0] frame_of(input logic [13:0] c, input bit bip);
    return {2'b00, c ^ {bip, 13'h0000}};
  endfunction : frame_of
  task automatic wait_v(input int s, input logic v, output int n);
    n = 0;
    @(negedge clk);
    while (sig(s) !== v && n < 400) begin
      @(negedge clk);
      n++;
    end
    if (n >= 400) begin
      fail_count++;
      $display("wait on signal %0d timed out", s);
      end_of_test();
    end
  endtask : wait_v
  // ----------------------------------------------------------------
  // One conversion, its readout and, if asked, a power-down cycle
  // ----------------------------------------------------------------
  task automatic run_conv(input logic [13:0] c, input bit sleep, input bit early);
    logic [15:0] w;
    logic [15:0] wu;
    int n;
    repeat (sadc_pkg::READ_GUARD_CYC) @(posedge clk);
    @(posedge clk);
    sample_code <= c;
    convert_start_n <= 1'b0;
    wait_v(0, 1'b1, n);
    `SADC_CHK(n <= 5, 1);
    `SADC_CHK(hold_mode, 1);
    // The core code changes mid-conversion; the frozen sample must win.
    @(posedge clk);
    sample_code <= ~c;
    if (!sleep) begin
      convert_start_n <= 1'b1;
    end
    wait_v(0, 1'b0, n);
    `SADC_CHK(n >= sadc_pkg::CONV_CYC - 4 && n <= sadc_pkg::CONV_CYC, 1);
    `SADC_CHK(power_down, sleep);
    wait_v(1, 1'b1, n);
    `SADC_CHK(serial_out, 0);
    host.read_frame(w, wu);
    `SADC_CHK(w, frame_of(c, 1'b1));
    `SADC_CHK(wu, frame_of(c, 1'b0));
    wait_v(1, 1'b0, n);
    `SADC_CHK(n >= 1 && n <= 8, 1);
    if (sleep) begin
      `SADC_CHK(power_down, 1);
      @(posedge clk);
      convert_start_n <= 1'b1;
      wait_v(2, 1'b0, n);
      `SADC_CHK(n <= 5, 1);
      if (early) begin
        // A start fall during wake-up is kept and converted once wake-up ends.
        c = 14'($urandom());
        repeat (sadc_pkg::READ_GUARD_CYC) @(posedge clk);
        @(posedge clk);
        sample_code <= c;
        convert_start_n <= 1'b0;
        wait_v(0, 1'b1, n);
        `SADC_CHK(n <= 5, 1);
        @(posedge clk);
        sample_code <= ~c;
        convert_start_n <= 1'b1;
        repeat (sadc_pkg::WAKE_CYC - 20) @(negedge clk);
        `SADC_CHK(busy, 1);
        wait_v(0, 1'b0, n);
        `SADC_CHK(n >= sadc_pkg::CONV_CYC - 10 && n <= sadc_pkg::CONV_CYC + 10, 1);
        `SADC_CHK(power_down, 0);
        wait_v(1, 1'b1, n);
        host.read_frame(w, wu);
        `SADC_CHK(w, frame_of(c, 1'b1));
        `SADC_CHK(wu, frame_of(c, 1'b0));
        wait_v(1, 1'b0, n);
        `SADC_CHK(n >= 1 && n <= 8, 1);
      end else begin
        repeat (sadc_pkg::WAKE_CYC + 10) @(negedge clk);
        `SADC_CHK({busy, power_down}, 0);
      end
    end
  endtask : run_conv
  // Three results wait in the shifter and both buffer entries before any read.
  task automatic run_queue();
    logic [13:0] q [3];
    logic [15:0] w;
    logic [15:0] wu;
    int n;
    for (int k = 0; k < 3; k++) begin
      q[k] = 14'($urandom());
      repeat (sadc_pkg::READ_GUARD_CYC) @(posedge clk);
      @(posedge clk);
      sample_code <= q[k];
      convert_start_n <= 1'b0;
      wait_v(0, 1'b1, n);
      `SADC_CHK(n <= 5, 1);
      @(posedge clk);
      convert_start_n <= 1'b1;
      wait_v(0, 1'b0, n);
      `SADC_CHK(n >= sadc_pkg::CONV_CYC - 4 && n <= sadc_pkg::CONV_CYC, 1);
    end
    for (int k = 0; k < 3; k++) begin
      wait_v(1, 1'b1, n);
      host.read_frame(w, wu);
      `SADC_CHK(w, frame_of(q[k], 1'b1));
      `SADC_CHK(wu, frame_of(q[k], 1'b0));
      wait_v(1, 1'b0, n);
      `SADC_CHK(n >= 1 && n <= 8, 1);
    end
  endtask : run_queue
  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    logic [13:0] c;
    rst_n = 1'b0;
    convert_start_n = 1'b1;
    sample_code = 14'h0000;
    void'($urandom(35129));
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    @(negedge clk);
    `SADC_CHK({busy, hold_mode, power_down, serial_out_en}, 0);
    for (int t = 0; t < 7; t++) begin
      c = (t == 0) ? 14'h0000 : (t == 1) ? 14'h3fff : (t == 2) ? 14'h2000 : 14'($urandom());
      run_conv(c, t == 1 || t == 4, t == 4);
      $display("test %0d done", t);
    end
    run_queue();
    $display("test 7 done");
    end_of_test();
  end
endmodule : sadc_top_tb_top
